// ===== design/csf_pkg.sv
package csf_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] CSF_FLAGS_ADDR   = 12'h000;
	localparam logic [11:0] CSF_CTRL_ADDR    = 12'h004;
	localparam logic [11:0] CSF_OPND_ADDR    = 12'h008;
	localparam logic [11:0] CSF_RESULT_ADDR  = 12'h00c;
	localparam logic [11:0] CSF_EVENT_ADDR   = 12'h010;

	// ************************************************************
	// flag bit positions
	// ************************************************************
	localparam int CSF_CARRY_BIT  = 0;
	localparam int CSF_NIBBLE_BIT = 1;
	localparam int CSF_ZERO_BIT   = 2;
	localparam int CSF_SLEEP_BIT  = 3;
	localparam int CSF_WDOG_BIT   = 4;
	localparam int CSF_DW         = 8;

	localparam logic [2:0]  CSF_ARITH_RESET = 3'h0;
	localparam logic [1:0]  CSF_CAUSE_RESET = 2'h3;
	localparam logic [2:0]  CSF_UNIMP_VALUE = 3'h0;

	// event register bits
	localparam int CSF_EV_KICK    = 0;
	localparam int CSF_EV_SLEEP   = 1;
	localparam int CSF_EV_TIMEOUT = 2;
	localparam int CSF_EV_POR     = 3;

	// ************************************************************
	// operations issued through the control register
	// ************************************************************
	typedef enum logic [3:0] {
		CSF_OP_NONE,
		CSF_OP_ADD,
		CSF_OP_SUB,
		CSF_OP_AND,
		CSF_OP_IOR,
		CSF_OP_XOR,
		CSF_OP_RLC,
		CSF_OP_RRC,
		CSF_OP_MOVE
	} csf_op_type;
endpackage : csf_pkg

// ===== design/csf_core_flags.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// How it works
// - an operation that targets the flag register keeps the zero, nibble or carry bits it updates from the flag logic and takes the others from the data.
// - the watchdog-expiry and sleep-entered bits ignore all data writes and move only on their events.
// - bits 7 to 5 of the flag register always read zero.
// - the watchdog-expiry bit is one after power-up, a kick or a sleep, and zero after a watchdog time-out with no kick or sleep in the same cycle.
// - the sleep-entered bit is one after power-up or a kick and zero after a sleep with no kick in the same cycle.
// - the zero flag is set for a zero arithmetic or logic result and cleared otherwise.
// - add and subtract load the nibble flag with the carry out of result bit 3.
// - add and subtract load the carry flag with the carry out of result bit 7.
// - subtraction adds the two's complement, so both carries mean no borrow.
// - rotate through carry loads carry with bit 7 on left and bit 0 on right.
module csf_core_flags (
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       por_n_in,
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [11:0]                paddr_in,
	input  wire logic [31:0]                pwdata_in,
	input  wire logic [3:0]                 pstrb_in,
	input  wire logic                       kick_in,
	input  wire logic                       sleep_in,
	input  wire logic                       timeout_in,
	output logic      [31:0]                prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	output logic      [csf_pkg::CSF_DW-1:0] flags_out
);
	import csf_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic [2:0]        arith;
	logic              wdog_bit;
	logic              sleep_bit;
	logic [CSF_DW-1:0] opnd_a;
	logic [CSF_DW-1:0] opnd_b;
	logic [CSF_DW-1:0] result;
	logic              ev_kick;
	logic              ev_sleep;
	logic              ev_timeout;
	logic              ev_por;

	logic              wr_en;
	logic              rd_en;
	logic              hit;
	logic              op_go;
	logic              dest_flags;
	csf_op_type        op_code;
	logic [CSF_DW-1:0] flags_view;
	logic [CSF_DW-1:0] next_result;
	logic [2:0]        next_arith;
	logic [2:0]        upd_mask;
	logic [CSF_DW:0]   sum;
	logic [4:0]        nsum;
	logic [CSF_DW-1:0] addend;
	logic              carry_in;

	// ************************************************************
	// apb decode
	// ************************************************************
	assign wr_en      = psel_in && penable_in && pwrite_in;
	assign rd_en      = psel_in && !penable_in && !pwrite_in; // read data caught in setup
	assign hit        = (paddr_in == CSF_FLAGS_ADDR) || (paddr_in == CSF_CTRL_ADDR) ||
	                    (paddr_in == CSF_OPND_ADDR) || (paddr_in == CSF_RESULT_ADDR) ||
	                    (paddr_in == CSF_EVENT_ADDR);
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !hit;

	// ctrl write: [3:0] op, [8] destination is the flag register
	assign op_go      = wr_en && (paddr_in == CSF_CTRL_ADDR) && pstrb_in[0];
	assign op_code    = csf_op_type'(pwdata_in[3:0]);
	assign dest_flags = pwdata_in[8] && pstrb_in[1];

	assign flags_view = {CSF_UNIMP_VALUE, wdog_bit, sleep_bit, arith};
	assign flags_out  = flags_view;

	// ************************************************************
	// alu
	// ************************************************************
	always_comb begin
		addend   = (op_code == CSF_OP_SUB) ? ~opnd_b : opnd_b;
		carry_in = (op_code == CSF_OP_SUB);
		sum      = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, carry_in};
		nsum     = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
		next_result = result;
		next_arith  = arith;
		upd_mask    = 3'h0;
		case (op_code)
			CSF_OP_ADD, CSF_OP_SUB: begin
				next_result = sum[CSF_DW-1:0];
				next_arith  = {(sum[CSF_DW-1:0] == 8'h00), nsum[4], sum[CSF_DW]};
				upd_mask    = 3'h7;
			end
			CSF_OP_AND, CSF_OP_IOR, CSF_OP_XOR: begin
				next_result = (op_code == CSF_OP_AND) ? (opnd_a & opnd_b) :
				              (op_code == CSF_OP_IOR) ? (opnd_a | opnd_b) : (opnd_a ^ opnd_b);
				next_arith[2] = (next_result == 8'h00);
				upd_mask    = 3'h4;
			end
			CSF_OP_RLC: begin
				next_result   = {opnd_a[CSF_DW-2:0], arith[0]};
				next_arith[0] = opnd_a[CSF_DW-1];
				upd_mask      = 3'h1;
			end
			CSF_OP_RRC: begin
				next_result   = {arith[0], opnd_a[CSF_DW-1:1]};
				next_arith[0] = opnd_a[0];
				upd_mask      = 3'h1;
			end
			CSF_OP_MOVE: begin
				next_result = opnd_a;
			end
			default: begin
				next_result = result;
			end
		endcase
	end

	// ************************************************************
	// operand and result registers
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			opnd_a <= 8'h00;
			opnd_b <= 8'h00;
		end else if (wr_en && paddr_in == CSF_OPND_ADDR) begin
			if (pstrb_in[0]) opnd_a <= pwdata_in[7:0];
			if (pstrb_in[1]) opnd_b <= pwdata_in[15:8];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			result <= 8'h00;
		end else if (op_go) begin
			result <= next_result;
		end
	end

	// ************************************************************
	// arithmetic flags, kept over non-power-on resets
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!por_n_in) begin
			arith <= CSF_ARITH_RESET;
		end else if (!reset_n_in) begin
			arith <= arith;
		end else if (op_go && dest_flags) begin
			// flag logic wins over the data write on updated bits
			arith <= (next_arith & upd_mask) | (next_result[2:0] & ~upd_mask);
		end else if (op_go) begin
			arith <= next_arith;
		end else if (wr_en && paddr_in == CSF_FLAGS_ADDR && pstrb_in[0]) begin
			arith <= pwdata_in[2:0];
		end
	end

	// ************************************************************
	// reset-cause bits, hardware events only
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!por_n_in) begin
			wdog_bit  <= CSF_CAUSE_RESET[1];
			sleep_bit <= CSF_CAUSE_RESET[0];
		end else if (kick_in) begin
			wdog_bit  <= 1'b1;
			sleep_bit <= 1'b1;
		end else if (sleep_in) begin
			wdog_bit  <= 1'b1;
			sleep_bit <= 1'b0;
		end else if (timeout_in) begin
			wdog_bit  <= 1'b0;
		end
	end

	// ************************************************************
	// sticky event log; set wins over write-one-to-clear
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ev_kick    <= 1'b0;
			ev_sleep   <= 1'b0;
			ev_timeout <= 1'b0;
			ev_por     <= 1'b1;
		end else begin
			if (kick_in)
				ev_kick <= 1'b1;
			else if (wr_en && paddr_in == CSF_EVENT_ADDR && pwdata_in[CSF_EV_KICK])
				ev_kick <= 1'b0;
			if (sleep_in)
				ev_sleep <= 1'b1;
			else if (wr_en && paddr_in == CSF_EVENT_ADDR && pwdata_in[CSF_EV_SLEEP])
				ev_sleep <= 1'b0;
			if (timeout_in)
				ev_timeout <= 1'b1;
			else if (wr_en && paddr_in == CSF_EVENT_ADDR && pwdata_in[CSF_EV_TIMEOUT])
				ev_timeout <= 1'b0;
			if (wr_en && paddr_in == CSF_EVENT_ADDR && pwdata_in[CSF_EV_POR])
				ev_por <= 1'b0;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (rd_en) begin
			case (paddr_in)
				CSF_FLAGS_ADDR:  prdata_out <= {24'h00_0000, flags_view};
				CSF_OPND_ADDR:   prdata_out <= {16'h0000, opnd_b, opnd_a};
				CSF_RESULT_ADDR: prdata_out <= {24'h00_0000, result};
				CSF_EVENT_ADDR:  prdata_out <= {28'h000_0000, ev_por, ev_timeout, ev_sleep,
				                                ev_kick};
				default:         prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence seq_kick;
		kick_in;
	endsequence

	// issue strobes split by destination, so each path has its own checks
	sequence seq_op_plain;
		op_go && !dest_flags;
	endsequence

	sequence seq_op_dest;
		op_go && dest_flags;
	endsequence

	// general reset with power steady: the arithmetic flags must ride through it
	sequence seq_warm_reset;
		!reset_n_in && por_n_in;
	endsequence

	sequence seq_flag_write;
		wr_en && (paddr_in == CSF_FLAGS_ADDR) && pstrb_in[0];
	endsequence

	sequence seq_flag_read;
		rd_en && (paddr_in == CSF_FLAGS_ADDR);
	endsequence

	// checks gated by run_ok pause while either reset is applied
	logic run_ok;
	assign run_ok = reset_n_in && por_n_in;

	// ************************************************************
	// register view and reset-cause bits
	// ************************************************************
	chk_unimp_zero: assert property (@(posedge clk_in) flags_out[7:5] == 3'h0)
		else $error("unimplemented flag bits not zero");
	chk_flag_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		seq_flag_read |=> (prdata_out == {24'h00_0000, $past(flags_view)}))
		else $error("flag read data wrong");
	chk_kick_sets: assert property (@(posedge clk_in) disable iff (!por_n_in)
		seq_kick |=> (wdog_bit && sleep_bit))
		else $error("kick did not set cause bits");
	chk_sleep_clear: assert property (@(posedge clk_in) disable iff (!por_n_in)
		(sleep_in && !kick_in) |=> (!sleep_bit && wdog_bit))
		else $error("sleep did not clear sleep bit");
	chk_timeout_clear: assert property (@(posedge clk_in) disable iff (!por_n_in)
		(timeout_in && !kick_in && !sleep_in) |=> !wdog_bit)
		else $error("timeout did not clear watchdog bit");
	// a data write must never reach the cause bits, so only events may move them
	chk_cause_locked: assert property (@(posedge clk_in) disable iff (!por_n_in)
		(!kick_in && !sleep_in && !timeout_in) |=> $stable({wdog_bit, sleep_bit}))
		else $error("cause bits changed without event");
	chk_flag_write: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_flag_write |=> (arith == $past(pwdata_in[2:0])))
		else $error("flag write did not land in bits 2 to 0");
	chk_por_clear: assert property (@(posedge clk_in)
		!por_n_in |=> (arith == 3'h0) && wdog_bit && sleep_bit)
		else $error("power-on values wrong");
	chk_arith_kept: assert property (@(posedge clk_in) disable iff (!por_n_in)
		seq_warm_reset |=> $stable(arith))
		else $error("arithmetic flags lost on general reset");

	// ************************************************************
	// flag logic
	// ************************************************************
	chk_zero_flag: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && upd_mask[2]) |=> (arith[2] == (result == 8'h00)))
		else $error("zero flag mismatch");
	chk_add_carry: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && op_code == CSF_OP_ADD) |=>
		(arith[0] == ({1'b0, $past(opnd_a)} + {1'b0, $past(opnd_b)} > 9'h0ff)))
		else $error("add carry mismatch");
	chk_add_nibble: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && op_code == CSF_OP_ADD) |=>
		(arith[1] == ({1'b0, $past(opnd_a[3:0])} + {1'b0, $past(opnd_b[3:0])} > 5'h0f)))
		else $error("add nibble carry mismatch");
	// borrow is the inverted carry, so no borrow reads as one
	chk_sub_borrow: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && op_code == CSF_OP_SUB) |=> (arith[0] == ($past(opnd_a) >= $past(opnd_b))))
		else $error("subtract borrow polarity wrong");
	chk_sub_nibble: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && op_code == CSF_OP_SUB) |=>
		(arith[1] == ($past(opnd_a[3:0]) >= $past(opnd_b[3:0]))))
		else $error("nibble borrow mismatch");
	chk_logic_keeps: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_op_plain ##0 (op_code inside {CSF_OP_AND, CSF_OP_IOR, CSF_OP_XOR}) |=>
		$stable(arith[1:0]))
		else $error("logic operation touched carry flags");
	chk_move_keeps: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_op_plain ##0 (op_code == CSF_OP_MOVE) |=> $stable(arith))
		else $error("move changed the flags");
	chk_rotate_left: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && op_code == CSF_OP_RLC) |=> (arith[0] == $past(opnd_a[7])))
		else $error("rotate left carry wrong");
	chk_rotate_right: assert property (@(posedge clk_in) disable iff (!run_ok)
		(op_go && op_code == CSF_OP_RRC) |=> (arith[0] == $past(opnd_a[0])))
		else $error("rotate right carry wrong");
	chk_rotate_keeps: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_op_plain ##0 (op_code inside {CSF_OP_RLC, CSF_OP_RRC}) |=> $stable(arith[2:1]))
		else $error("rotate touched zero or nibble flag");

	// ************************************************************
	// flag register as destination
	// ************************************************************
	// for an add into the flags, the flag logic must win on the carry and zero bits
	chk_dest_protect: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_op_dest ##0 (op_code == CSF_OP_ADD) |=>
		(arith[0] == ({1'b0, $past(opnd_a)} + {1'b0, $past(opnd_b)} > 9'h0ff)) &&
		(arith[2] == (result == 8'h00)))
		else $error("flag logic lost to data write");
	chk_dest_rotate: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_op_dest ##0 (op_code == CSF_OP_RLC) |=>
		(arith[0] == $past(opnd_a[7])) && (arith[2:1] == result[2:1]))
		else $error("rotate into flags mixed up its bits");
	chk_dest_logic: assert property (@(posedge clk_in) disable iff (!run_ok)
		seq_op_dest ##0 (op_code inside {CSF_OP_AND, CSF_OP_IOR, CSF_OP_XOR}) |=>
		(arith[2] == (result == 8'h00)) && (arith[1:0] == result[1:0]))
		else $error("logic result into flags mixed up its bits");
endmodule : csf_core_flags

// ===== verif/csf_core_flags_tb.sv
`timescale 1ns/1ps
module csf_core_flags_tb;
	import csf_pkg::*;
	logic                clk_in;
	logic                reset_n_in;
	logic                por_n_in;
	logic                psel_in;
	logic                penable_in;
	logic                pwrite_in;
	logic [11:0]         paddr_in;
	logic [31:0]         pwdata_in;
	logic [3:0]          pstrb_in;
	logic                kick_in;
	logic                sleep_in;
	logic                timeout_in;
	logic [31:0]         prdata_out;
	logic                pready_out;
	logic                pslverr_out;
	logic [CSF_DW-1:0]   flags_out;
	logic [2:0]          m;
	logic [1:0]          cz;
	logic [31:0]         rd;
	logic                err;
	int                  fails;
	int                  compares;

	csf_core_flags DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .kick_in(kick_in),
		.sleep_in(sleep_in), .timeout_in(timeout_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .flags_out(flags_out));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// ************************************************************
	// checking and bus tasks
	// ************************************************************
	task automatic give_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// waits for pready however long the slave takes; only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s);
		@(posedge clk_in);
		psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= wr;
		paddr_in <= a; pwdata_in <= d; pstrb_in <= s;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic chk_flags;
		apb(1'b0, CSF_FLAGS_ADDR, 32'h0, 4'h0);
		chk("flags read", {27'h0, cz, m}, rd);
		chk("flags port", {24'h0, 3'h0, cz, m}, {24'h0, flags_out});
	endtask : chk_flags

	task automatic do_reset(input logic por);
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		por_n_in <= ~por;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		por_n_in <= 1'b1;
		if (por) begin
			m = 3'h0;
			cz = 2'h3;
		end
	endtask : do_reset

	task automatic pulse(input logic k, input logic s, input logic t);
		@(posedge clk_in);
		kick_in <= k; sleep_in <= s; timeout_in <= t;
		@(posedge clk_in);
		kick_in <= 1'b0; sleep_in <= 1'b0; timeout_in <= 1'b0;
		if (k) cz = 2'h3;
		else if (s) cz = 2'h2;
		else if (t) cz = {1'b0, cz[0]};
		chk_flags();
	endtask : pulse

	// m holds {zero, nibble, carry}; expected values built from the operands and the previous m
	task automatic run_op(input csf_op_type op, input logic [7:0] a, input logic [7:0] b,
			input logic dest);
		logic [8:0] s9;
		logic [4:0] n5;
		logic [7:0] res;
		logic [2:0] upd;
		s9 = 9'h0; n5 = 5'h0; res = a; upd = 3'h0;
		case (op)
			CSF_OP_ADD, CSF_OP_SUB: begin
				s9 = (op == CSF_OP_ADD) ? {1'b0, a} + {1'b0, b} : {1'b0, a} + {1'b0, ~b} + 9'h1;
				n5 = (op == CSF_OP_ADD) ? {1'b0, a[3:0]} + {1'b0, b[3:0]}
					: {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h1;
				res = s9[7:0];
				m = {res == 8'h0, n5[4], s9[8]};
				upd = 3'h7;
			end
			CSF_OP_AND, CSF_OP_IOR, CSF_OP_XOR: begin
				res = (op == CSF_OP_AND) ? a & b : (op == CSF_OP_IOR) ? a | b : a ^ b;
				m[2] = (res == 8'h0);
				upd = 3'h4;
			end
			CSF_OP_RLC: begin
				res = {a[6:0], m[0]};
				m[0] = a[7];
				upd = 3'h1;
			end
			CSF_OP_RRC: begin
				res = {m[0], a[7:1]};
				m[0] = a[0];
				upd = 3'h1;
			end
			default: res = a;
		endcase
		if (dest) m = (m & upd) | (res[2:0] & ~upd);
		apb(1'b1, CSF_OPND_ADDR, {16'h0, b, a}, 4'h3);
		apb(1'b1, CSF_CTRL_ADDR, {23'h0, dest, 4'h0, op}, 4'h3);
		if (!dest) begin
			apb(1'b0, CSF_RESULT_ADDR, 32'h0, 4'h0);
			chk("result", {24'h0, res}, rd);
		end
		chk_flags();
	endtask : run_op

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		fails = 0; compares = 0; m = 3'h0; cz = 2'h3;
		reset_n_in = 1'b0; por_n_in = 1'b0; psel_in = 1'b0; penable_in = 1'b0;
		pwrite_in = 1'b0; paddr_in = 12'h000; pwdata_in = 32'h0; pstrb_in = 4'h0;
		kick_in = 1'b0; sleep_in = 1'b0; timeout_in = 1'b0;
		do_reset(1'b1);
		chk_flags();
		apb(1'b1, CSF_FLAGS_ADDR, 32'hff, 4'h1);
		m = 3'h7;
		chk_flags();
		apb(1'b1, CSF_FLAGS_ADDR, 32'h00, 4'h0);
		chk_flags();
		apb(1'b1, CSF_FLAGS_ADDR, 32'h00, 4'h1);
		m = 3'h0;
		run_op(CSF_OP_ADD, 8'h0f, 8'h01, 1'b0);
		run_op(CSF_OP_ADD, 8'hff, 8'h01, 1'b0);
		run_op(CSF_OP_ADD, 8'h80, 8'h80, 1'b0);
		run_op(CSF_OP_ADD, 8'h12, 8'h34, 1'b0);
		run_op(CSF_OP_SUB, 8'h05, 8'h05, 1'b0);
		run_op(CSF_OP_SUB, 8'h03, 8'h05, 1'b0);
		run_op(CSF_OP_SUB, 8'h10, 8'h01, 1'b0);
		run_op(CSF_OP_AND, 8'hf0, 8'h0f, 1'b0);
		run_op(CSF_OP_IOR, 8'h01, 8'h00, 1'b0);
		run_op(CSF_OP_XOR, 8'h5a, 8'h5a, 1'b0);
		run_op(CSF_OP_RLC, 8'h81, 8'h00, 1'b0);
		run_op(CSF_OP_RRC, 8'h02, 8'h00, 1'b0);
		run_op(CSF_OP_RRC, 8'h01, 8'h00, 1'b0);
		run_op(CSF_OP_MOVE, 8'h00, 8'h00, 1'b0);
		run_op(CSF_OP_AND, 8'h04, 8'h0c, 1'b1);
		run_op(CSF_OP_ADD, 8'hff, 8'h01, 1'b1);
		run_op(CSF_OP_RLC, 8'h03, 8'h00, 1'b1);
		apb(1'b0, CSF_OPND_ADDR, 32'h0, 4'h0);
		chk("operands", 32'h0000_0003, rd);
		pulse(1'b0, 1'b1, 1'b0);
		pulse(1'b0, 1'b0, 1'b1);
		pulse(1'b1, 1'b0, 1'b0);
		pulse(1'b1, 1'b1, 1'b0);
		pulse(1'b0, 1'b1, 1'b1);
		apb(1'b0, CSF_EVENT_ADDR, 32'h0, 4'h0);
		chk("event log", 32'h0000_000f, rd);
		apb(1'b1, CSF_EVENT_ADDR, 32'h0000_0007, 4'h1);
		apb(1'b0, CSF_EVENT_ADDR, 32'h0, 4'h0);
		chk("event clear", 32'h0000_0008, rd);
		do_reset(1'b0);
		chk_flags();
		apb(1'b0, 12'h020, 32'h0, 4'h0);
		chk("unmapped read", 32'h0000_0000, rd);
		chk("unmapped error", 32'h1, {31'h0, err});
		do_reset(1'b1);
		chk_flags();
		give_verdict();
	end

	initial begin
		#1000000;
		fails++;
		give_verdict();
	end
endmodule : csf_core_flags_tb
